/* File: hw/reset_cause_cfg.svh */
// Constants of the reset-cause vector generator.
// Assumes one system clock; included by package and design files.
`ifndef RESET_CAUSE_CFG_SVH
`define RESET_CAUSE_CFG_SVH

// =====================================================
// Register map
`define VECTOR_ADDR       16'h019E
`define WORD_ADDR_MASK    16'hFFFE
`define IDLE_CODE         8'h00

// =====================================================
// Cause slots, code is two times slot plus two
`define SLOT_BROWNOUT     5'h00
`define SLOT_RESET_PIN    5'h01
`define SLOT_SW_BROWNOUT  5'h02
`define SLOT_LPM_WAKEUP   5'h03
`define SLOT_SECURITY     5'h04
`define SLOT_HIGH_SUPPLY  5'h06
`define SLOT_SW_POWERON   5'h09
`define SLOT_WDT_EXPIRY   5'h0A
`define SLOT_WDT_KEY      5'h0B
`define SLOT_NVM_KEY      5'h0C
`define SLOT_NVM_ECC      5'h0D
`define SLOT_PERIPH_FETCH 5'h0E
`define SLOT_PMM_KEY      5'h0F
`define SLOT_MPU_KEY      5'h10
`define SLOT_CS_KEY       5'h11
`define SLOT_IP_SEG       5'h12
`define SLOT_INFO_SEG     5'h13
`define SLOT_SEG_ONE      5'h14
`define SLOT_SEG_TWO      5'h15
`define SLOT_SEG_THREE    5'h16
`define SLOT_ACCESS_TIME  5'h17

// =====================================================
// Masks and reset values
`define CAUSE_VALID_MASK  24'hFFFE5F
`define BROWNOUT_ONLY     24'h000001
`define PENDING_RESET     24'h000001

`endif

/* File: hw/reset_cause_pkg.sv */
// Types and helpers of the reset-cause vector generator.
// Assumes the constants header is on the include path.
`include "reset_cause_cfg.svh"

package reset_cause_pkg;

   typedef logic [23:0] cause_set_type;
   typedef logic [7:0]  code_type;
   typedef logic [4:0]  slot_type;

   // Vector code of a cause slot
   function automatic code_type slot_code(input slot_type slot);
      code_type code;
      code = {2'h0, slot, 1'b0} + 8'h02;
      return code;
   endfunction

endpackage

/* File: hw/reset_cause_priority.sv */
// Priority encoder of recorded reset causes.
// Assumes slot zero is the highest priority.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_cfg.svh"

module reset_cause_priority (
   // Recorded causes
   input  wire reset_cause_pkg::cause_set_type pending,
   // Highest pending cause
   output var reset_cause_pkg::code_type       top_code,
   output var reset_cause_pkg::cause_set_type  top_onehot
);

   always_comb begin
      top_code   = `IDLE_CODE;
      top_onehot = '0;
      for (int i = 23; i >= 0; i--) begin
         if (pending[i]) begin
            top_code   = reset_cause_pkg::slot_code(5'(i));
            top_onehot = reset_cause_pkg::cause_set_type'(24'h000001 << i);
         end
      end
   end

endmodule

`default_nettype wire

/* File: hw/reset_cause_vector_generator.sv */
// Reset-cause vector generator with read-to-clear vector register.
// Assumes event inputs are one-cycle or level strobes on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_cfg.svh"

module reset_cause_vector_generator (
   // Clock, reset, enable
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire logic                    ce,
   // Peripheral read port
   input  wire logic                    rd_en,
   input  wire logic [15:0]             rd_addr,
   output logic      [15:0]             rd_data_q,
   output logic                         rd_ack_q,
   // Status
   output logic                         cause_pending_q,
   // Brownout class causes
   input  wire logic                    poweron_brownout,
   input  wire logic                    reset_pin_flag,
   input  wire logic                    software_brownout_request,
   input  wire logic                    lpm_wakeup,
   input  wire logic                    security_violation,
   input  wire logic                    high_supply_supervisor_flag,
   // Power-on class causes
   input  wire logic                    software_poweron_request,
   // Power-up-clear class causes
   input  wire logic                    watchdog_expiry_flag,
   input  wire logic                    watchdog_key_error,
   input  wire logic                    nvm_controller_key_error,
   input  wire logic                    nvm_uncorrectable_error,
   input  wire logic                    peripheral_fetch_error,
   input  wire logic                    power_manager_key_error,
   input  wire logic                    protection_unit_key_error,
   input  wire logic                    clock_system_key_error,
   input  wire logic                    ip_segment_violation_flag,
   input  wire logic                    info_segment_violation_flag,
   input  wire logic                    segment_one_violation_flag,
   input  wire logic                    segment_two_violation_flag,
   input  wire logic                    segment_three_violation_flag,
   input  wire logic                    access_time_error_flag
);

   // =====================================================
   // Declarations
   reset_cause_pkg::cause_set_type pending_q;
   reset_cause_pkg::cause_set_type pending_d;
   reset_cause_pkg::cause_set_type event_vec;
   reset_cause_pkg::cause_set_type top_onehot;
   reset_cause_pkg::code_type      top_code;
   logic [15:0]                    rd_data_d;
   logic                           rd_ack_d;
   logic                           cause_pending_d;
   logic                           rd_hit;
   logic                           any_event;

   // =====================================================
   // Address decode
   assign rd_hit = rd_en && ((rd_addr & `WORD_ADDR_MASK) == `VECTOR_ADDR);

   // =====================================================
   // Events into cause slots
   always_comb begin
      event_vec = '0;
      event_vec[`SLOT_BROWNOUT]     = poweron_brownout;
      event_vec[`SLOT_RESET_PIN]    = reset_pin_flag;
      event_vec[`SLOT_SW_BROWNOUT]  = software_brownout_request;
      event_vec[`SLOT_LPM_WAKEUP]   = lpm_wakeup;
      event_vec[`SLOT_SECURITY]     = security_violation;
      event_vec[`SLOT_HIGH_SUPPLY]  = high_supply_supervisor_flag;
      event_vec[`SLOT_SW_POWERON]   = software_poweron_request;
      event_vec[`SLOT_WDT_EXPIRY]   = watchdog_expiry_flag;
      event_vec[`SLOT_WDT_KEY]      = watchdog_key_error;
      event_vec[`SLOT_NVM_KEY]      = nvm_controller_key_error;
      event_vec[`SLOT_NVM_ECC]      = nvm_uncorrectable_error;
      event_vec[`SLOT_PERIPH_FETCH] = peripheral_fetch_error;
      event_vec[`SLOT_PMM_KEY]      = power_manager_key_error;
      event_vec[`SLOT_MPU_KEY]      = protection_unit_key_error;
      event_vec[`SLOT_CS_KEY]       = clock_system_key_error;
      event_vec[`SLOT_IP_SEG]       = ip_segment_violation_flag;
      event_vec[`SLOT_INFO_SEG]     = info_segment_violation_flag;
      event_vec[`SLOT_SEG_ONE]      = segment_one_violation_flag;
      event_vec[`SLOT_SEG_TWO]      = segment_two_violation_flag;
      event_vec[`SLOT_SEG_THREE]    = segment_three_violation_flag;
      event_vec[`SLOT_ACCESS_TIME]  = access_time_error_flag;
   end

   assign any_event = |event_vec;

   // =====================================================
   // Highest pending cause
   reset_cause_priority u_priority (
      .pending    (pending_q),
      .top_code   (top_code),
      .top_onehot (top_onehot)
   );

   // =====================================================
   // Next state
   always_comb begin
      pending_d = pending_q;
      rd_data_d = rd_data_q;
      rd_ack_d  = 1'b0;
      if (rd_hit) begin
         // Return code, drop it from the set
         rd_data_d = {8'h00, top_code};
         rd_ack_d  = 1'b1;
         pending_d = pending_q & ~top_onehot;
      end
      // New events win over the read clear
      pending_d = (pending_d | event_vec) & `CAUSE_VALID_MASK;
      if (poweron_brownout) begin
         pending_d = `BROWNOUT_ONLY;
      end
      cause_pending_d = |pending_d;
   end

   // =====================================================
   // State registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pending_q       <= `PENDING_RESET;
         rd_data_q       <= 16'h0000;
         rd_ack_q        <= 1'b0;
         cause_pending_q <= 1'b1;
      end else if (ce) begin
         pending_q       <= pending_d;
         rd_data_q       <= rd_data_d;
         rd_ack_q        <= rd_ack_d;
         cause_pending_q <= cause_pending_d;
      end
   end

   // =====================================================
   // Assertions
   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (reset);

   a_idle_reads_zero: assert property (
      (ce && rd_hit && pending_q == '0 && !any_event)
      |=> (rd_ack_q && rd_data_q == 16'h0000)
   ) else $error("idle vector read did not return zero");

   a_brownout_first: assert property (
      (ce && rd_hit && pending_q[0])
      |=> (rd_data_q == 16'h0002)
   ) else $error("brownout not reported first");

   a_reserved_hidden: assert property (
      rd_ack_q |-> !(rd_data_q inside {16'h000C, 16'h0010, 16'h0012})
   ) else $error("reserved code reported");

   a_reserved_upper: assert property (
      rd_ack_q |-> (rd_data_q[15:6] == 10'h000 && !rd_data_q[0]
                    && rd_data_q <= 16'h0030)
   ) else $error("code outside the defined range");

   a_supply_code: assert property (
      (ce && rd_hit && pending_q[5:0] == 6'h00 && pending_q[6])
      |=> (rd_data_q == 16'h000E)
   ) else $error("supply supervisor code wrong");

   a_poweron_code: assert property (
      (ce && rd_hit && pending_q[8:0] == 9'h000 && pending_q[9])
      |=> (rd_data_q == 16'h0014)
   ) else $error("software power-on code wrong");

   a_watchdog_code: assert property (
      (ce && rd_hit && pending_q[9:0] == 10'h000 && pending_q[10])
      |=> (rd_data_q == 16'h0016)
   ) else $error("watchdog expiry code wrong");

   a_access_code: assert property (
      (ce && rd_hit && pending_q[22:0] == 23'h000000 && pending_q[23])
      |=> (rd_data_q == 16'h0030)
   ) else $error("access time code wrong");

   a_read_clears: assert property (
      (ce && rd_hit && !any_event)
      |=> (pending_q == ($past(pending_q) & ~$past(top_onehot)))
   ) else $error("read did not clear reported cause");

   a_read_drains: assert property (
      (ce && rd_hit && !any_event && pending_q == 24'h000001)
      ##1 (ce && rd_hit && !any_event)
      |=> (rd_data_q == 16'h0000)
   ) else $error("second read after last cause not zero");

   a_brownout_wipes: assert property (
      (ce && poweron_brownout)
      |=> (pending_q == 24'h000001 && cause_pending_q)
   ) else $error("brownout did not wipe other causes");

   a_causes_accumulate: assert property (
      (ce && !poweron_brownout && !rd_hit)
      |=> (($past(pending_q) & ~pending_q) == '0)
   ) else $error("recorded cause lost without a read");

   a_event_wins: assert property (
      (ce && watchdog_expiry_flag && !poweron_brownout)
      |=> pending_q[10]
   ) else $error("watchdog expiry not recorded");

   a_key_recorded: assert property (
      (ce && clock_system_key_error && !poweron_brownout)
      |=> pending_q[17]
   ) else $error("clock system key error not recorded");

   a_segment_recorded: assert property (
      (ce && segment_one_violation_flag && !poweron_brownout)
      |=> pending_q[20]
   ) else $error("segment one violation not recorded");

   a_freeze_hold: assert property (
      !ce |=> ($stable(pending_q) && $stable(rd_data_q) && $stable(rd_ack_q))
   ) else $error("state moved while clock enable low");

   a_ack_single: assert property (
      (ce && !rd_hit) |=> !rd_ack_q
   ) else $error("acknowledge without a vector read");

   a_pin_code: assert property (
      (ce && rd_hit && !pending_q[0] && pending_q[1])
      |=> (rd_data_q == 16'h0004)
   ) else $error("reset pin code wrong");

   a_soft_brownout_code: assert property (
      (ce && rd_hit && pending_q[1:0] == '0 && pending_q[2])
      |=> (rd_data_q == 16'h0006)
   ) else $error("software brownout code wrong");

   a_wakeup_code: assert property (
      (ce && rd_hit && pending_q[2:0] == '0 && pending_q[3])
      |=> (rd_data_q == 16'h0008)
   ) else $error("wakeup code wrong");

   a_security_code: assert property (
      (ce && rd_hit && pending_q[3:0] == '0 && pending_q[4])
      |=> (rd_data_q == 16'h000A)
   ) else $error("security violation code wrong");

   a_watchdog_key_code: assert property (
      (ce && rd_hit && pending_q[10:0] == '0 && pending_q[11])
      |=> (rd_data_q == 16'h0018)
   ) else $error("watchdog key code wrong");

   a_nvm_key_code: assert property (
      (ce && rd_hit && pending_q[11:0] == '0 && pending_q[12])
      |=> (rd_data_q == 16'h001A)
   ) else $error("memory controller key code wrong");

   a_ecc_code: assert property (
      (ce && rd_hit && pending_q[12:0] == '0 && pending_q[13])
      |=> (rd_data_q == 16'h001C)
   ) else $error("uncorrectable error code wrong");

   a_fetch_code: assert property (
      (ce && rd_hit && pending_q[13:0] == '0 && pending_q[14])
      |=> (rd_data_q == 16'h001E)
   ) else $error("peripheral fetch code wrong");

   a_power_key_code: assert property (
      (ce && rd_hit && pending_q[14:0] == '0 && pending_q[15])
      |=> (rd_data_q == 16'h0020)
   ) else $error("power manager key code wrong");

   a_protect_key_code: assert property (
      (ce && rd_hit && pending_q[15:0] == '0 && pending_q[16])
      |=> (rd_data_q == 16'h0022)
   ) else $error("protection unit key code wrong");

   a_clock_key_code: assert property (
      (ce && rd_hit && pending_q[16:0] == '0 && pending_q[17])
      |=> (rd_data_q == 16'h0024)
   ) else $error("clock system key code wrong");

   a_ip_seg_code: assert property (
      (ce && rd_hit && pending_q[17:0] == '0 && pending_q[18])
      |=> (rd_data_q == 16'h0026)
   ) else $error("ip segment code wrong");

   a_info_seg_code: assert property (
      (ce && rd_hit && pending_q[18:0] == '0 && pending_q[19])
      |=> (rd_data_q == 16'h0028)
   ) else $error("info segment code wrong");

   a_seg_one_code: assert property (
      (ce && rd_hit && pending_q[19:0] == '0 && pending_q[20])
      |=> (rd_data_q == 16'h002A)
   ) else $error("segment one code wrong");

   a_seg_two_code: assert property (
      (ce && rd_hit && pending_q[20:0] == '0 && pending_q[21])
      |=> (rd_data_q == 16'h002C)
   ) else $error("segment two code wrong");

   a_seg_three_code: assert property (
      (ce && rd_hit && pending_q[21:0] == '0 && pending_q[22])
      |=> (rd_data_q == 16'h002E)
   ) else $error("segment three code wrong");

   a_pin_recorded: assert property (
      (ce && reset_pin_flag && !poweron_brownout)
      |=> pending_q[1]
   ) else $error("reset pin event not recorded");

   a_supply_recorded: assert property (
      (ce && high_supply_supervisor_flag && !poweron_brownout)
      |=> pending_q[6]
   ) else $error("supply supervisor event not recorded");

   a_poweron_recorded: assert property (
      (ce && software_poweron_request && !poweron_brownout)
      |=> pending_q[9]
   ) else $error("software power-on not recorded");

   a_nvm_key_recorded: assert property (
      (ce && nvm_controller_key_error && !poweron_brownout)
      |=> pending_q[12]
   ) else $error("memory controller key error not recorded");

   a_ecc_recorded: assert property (
      (ce && nvm_uncorrectable_error && !poweron_brownout)
      |=> pending_q[13]
   ) else $error("uncorrectable error not recorded");

   a_ip_seg_recorded: assert property (
      (ce && ip_segment_violation_flag && !poweron_brownout)
      |=> pending_q[18]
   ) else $error("ip segment violation not recorded");

   a_access_recorded: assert property (
      (ce && access_time_error_flag && !poweron_brownout)
      |=> pending_q[23]
   ) else $error("access time error not recorded");

endmodule

`default_nettype wire

/* File: verif/reset_cause_vector_generator_test.sv */
// Self-checking testbench of the reset-cause vector generator.
// Assumes the package and design sources are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module reset_cause_vector_generator_test;

   // =====================================================
   // Stimulus and observed signals
   logic        sys_clk         = 1'b0;
   logic        reset           = 1'b1;
   logic        ce              = 1'b1;
   logic        rd_en           = 1'b0;
   logic [15:0] rd_addr         = 16'h0000;
   logic [20:0] ev              = 21'h000000;
   logic [15:0] rd_data_q;
   logic        rd_ack_q;
   logic        cause_pending_q;
   logic [20:0] mask;
   integer      err_count       = 0;
   integer      samples_checked = 0;
   integer      seed            = 32'h4D0184D6;

   always #4 sys_clk = ~sys_clk;

   reset_cause_vector_generator dut (
      .sys_clk                      (sys_clk),
      .reset                        (reset),
      .ce                           (ce),
      .rd_en                        (rd_en),
      .rd_addr                      (rd_addr),
      .rd_data_q                    (rd_data_q),
      .rd_ack_q                     (rd_ack_q),
      .cause_pending_q              (cause_pending_q),
      .poweron_brownout             (ev[0]),
      .reset_pin_flag               (ev[1]),
      .software_brownout_request    (ev[2]),
      .lpm_wakeup                   (ev[3]),
      .security_violation           (ev[4]),
      .high_supply_supervisor_flag  (ev[5]),
      .software_poweron_request     (ev[6]),
      .watchdog_expiry_flag         (ev[7]),
      .watchdog_key_error           (ev[8]),
      .nvm_controller_key_error     (ev[9]),
      .nvm_uncorrectable_error      (ev[10]),
      .peripheral_fetch_error       (ev[11]),
      .power_manager_key_error      (ev[12]),
      .protection_unit_key_error    (ev[13]),
      .clock_system_key_error       (ev[14]),
      .ip_segment_violation_flag    (ev[15]),
      .info_segment_violation_flag  (ev[16]),
      .segment_one_violation_flag   (ev[17]),
      .segment_two_violation_flag   (ev[18]),
      .segment_three_violation_flag (ev[19]),
      .access_time_error_flag       (ev[20])
   );

   // =====================================================
   // Expected vector code of each event input
   function automatic logic [15:0] code_of(input integer i);
      logic [7:0] t [0:20];
      t = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0E, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C,
            8'h1E, 8'h20, 8'h22, 8'h24, 8'h26, 8'h28, 8'h2A, 8'h2C, 8'h2E, 8'h30};
      return {8'h00, t[i]};
   endfunction

   // =====================================================
   // Bench tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One clock cycle; read and event inputs set once, just after the edge
   task automatic step(input logic en, input logic [15:0] a, input logic [20:0] m);
      rd_en = en;
      rd_addr = a;
      ev = m;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic read_exp(input logic [15:0] a, input logic [20:0] m, input logic [15:0] exp);
      step(1'b1, a, m);
      check({15'h0000, rd_ack_q}, 16'h0001);
      check(rd_data_q, exp);
   endtask

   task automatic results;
      if (err_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      results();
   end

   // =====================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      check({15'h0000, cause_pending_q}, 16'h0001);
      read_exp(16'h019E, 21'h000000, 16'h0002);
      read_exp(16'h019E, 21'h000000, 16'h0000);
      check({15'h0000, cause_pending_q}, 16'h0000);
      // Each cause alone, read back then empty
      for (int i = 0; i < 21; i++) begin
         step(1'b0, 16'h0000, 21'h000001 << i);
         read_exp(16'h019E, 21'h000000, code_of(i));
         read_exp(16'h019E, 21'h000000, 16'h0000);
      end
      // Random sets drained back to back in priority order
      repeat (20) begin
         mask = 21'($random(seed)) & 21'h1FFFFE;
         step(1'b0, 16'h0000, mask);
         for (int i = 1; i < 21; i++)
            if (mask[i])
               read_exp(16'h019E, 21'h000000, code_of(i));
         read_exp(16'h019E, 21'h000000, 16'h0000);
         check({15'h0000, cause_pending_q}, 16'h0000);
      end
      // Brownout with others in the same cycle, and after others
      step(1'b0, 16'h0000, 21'h1FFFFF);
      read_exp(16'h019E, 21'h000000, 16'h0002);
      read_exp(16'h019E, 21'h000000, 16'h0000);
      step(1'b0, 16'h0000, 21'($random(seed)) | 21'h000002);
      step(1'b0, 16'h0000, 21'h000001);
      read_exp(16'h019E, 21'h000000, 16'h0002);
      read_exp(16'h019E, 21'h000000, 16'h0000);
      // Event arriving while its own code is read stays recorded
      step(1'b0, 16'h0000, 21'h000080);
      read_exp(16'h019F, 21'h000080, 16'h0016);
      read_exp(16'h019E, 21'h000000, 16'h0016);
      read_exp(16'h019E, 21'h000000, 16'h0000);
      // Unmapped address: no answer, data held
      step(1'b0, 16'h0000, 21'h000100);
      step(1'b1, 16'h0190, 21'h000000);
      check({15'h0000, rd_ack_q}, 16'h0000);
      check(rd_data_q, 16'h0000);
      read_exp(16'h019E, 21'h000000, 16'h0018);
      // Disabled clock enable ignores events and reads
      step(1'b0, 16'h0000, 21'h000000);
      ce = 1'b0;
      step(1'b0, 16'h0000, 21'h000004);
      step(1'b1, 16'h019E, 21'h000000);
      check({15'h0000, rd_ack_q}, 16'h0000);
      check(rd_data_q, 16'h0018);
      ce = 1'b1;
      read_exp(16'h019E, 21'h000000, 16'h0000);
      // Mid-run reset leaves only the brownout cause
      step(1'b0, 16'h0000, 21'h000100);
      reset = 1'b1;
      step(1'b0, 16'h0000, 21'h000200);
      reset = 1'b0;
      check({15'h0000, cause_pending_q}, 16'h0001);
      read_exp(16'h019E, 21'h000000, 16'h0002);
      read_exp(16'h019E, 21'h000000, 16'h0000);
      step(1'b0, 16'h0000, 21'h000000);
      results();
   end

endmodule

`default_nettype wire
